// >>> verilog/branch_unit_defines.svh
// Register map, field positions, reset values and limits of the branch unit
`ifndef BRANCH_UNIT_DEFINES_SVH
`define BRANCH_UNIT_DEFINES_SVH

`define OFS_OP        8'h00
`define OFS_OFFSET    8'h04
`define OFS_JLEN      8'h08
`define OFS_CODES     8'h0C
`define OFS_CONFIG    8'h10
`define OFS_GO        8'h14
`define OFS_RESULT    8'h18
`define OFS_STATUS    8'h1C
`define OFS_CLEAR     8'h20
`define OFS_ENABLE    8'h24

`define OP_FORM_LSB   0
`define OP_BANK_LSB   2
`define OP_INNUM_LSB  6
`define OP_COND_BIT   13
`define OP_WIDTH      14

`define RES_LOAD_BIT  16
`define RES_STEP_BIT  17
`define RES_BUSY_BIT  18

`define ST_DONE_BIT   0
`define ST_INVAL_BIT  1
`define ST_BCDERR_BIT 2
`define ST_BADCMD_BIT 3
`define ST_WIDTH      4

`define RST_OP        14'h0000
`define RST_OFFSET    14'h0000
`define RST_JLEN      7'h00
`define RST_CODES     20'hAAAAA
`define RST_ENABLE    4'h0

`define MAX_BLOCK     16'h0BB7
`define BANK_BIN_LO   4'h1
`define BANK_BIN_HI   4'h2
`define BANK_BIN_ALL  4'h3
`define BANK_LAST     4'h9
`define BCD_DIGIT_MAX 4'h9
`define IN_BASE_LAST  7'h10
`define IN_EXP_LAST   7'h50
`define IN_HIGH_FIRST 7'h51
`define IN_HIGH_LAST  7'h58
`define CODE_ON       2'h1

`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// >>> verilog/branch_unit_pkg.sv
// Types shared by the branch unit
package branch_unit_pkg;

    typedef enum logic [1:0] {
        FORM_BINARY,
        FORM_DECIMAL,
        FORM_SINGLE,
        FORM_COMPARE
    } form_t;

    typedef enum logic {
        ST_IDLE,
        ST_EVAL
    } state_t;

endpackage

// >>> verilog/input_sync.sv
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ps

module input_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // The first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;

endmodule

// >>> verilog/input_driven_branch_unit.sv
// Input-driven branch evaluation unit with AXI4-Lite register access
`timescale 1ns/1ps
`include "branch_unit_defines.svh"

module input_driven_branch_unit (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [99:0] AUX_IN,
    input wire logic [99:0] AUX_OUT_STATE,
    output logic BRANCH_LOAD,
    output logic [11:0] BRANCH_TARGET,
    output logic BRANCH_STEP,
    output logic DIAG_INVALID_BLOCK,
    output logic DIAG_DECIMAL_INPUT,
    output logic IRQ
);

    ////////////////////////////////////////////////////////////////////////////
    logic [99:0] aux_in_sync;
    logic aw_hold_ff, w_hold_ff, awready_ff, wready_ff, bvalid_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff;
    logic arready_ff, rvalid_ff;
    logic [31:0] rdata_ff, rd_data_c;
    logic [1:0] rresp_ff;
    logic rd_err_c, wr_en_c, wr_err_c;
    logic [13:0] op_ff, offset_ff;
    logic [6:0] jlen_ff;
    logic [19:0] codes_ff;
    logic exp_fitted_ff;
    logic [3:0] enable_ff, stat_ff, stat_set_c, stat_clr_c;
    logic [18:0] result_ff;
    branch_unit_pkg::state_t st_ff;
    logic [99:0] snap_in_ff, snap_out_ff;
    logic load_ff, step_ff, inval_ff, bcderr_ff, irq_ff;
    logic [11:0] target_ff;
    logic go_c;
    branch_unit_pkg::form_t form_c;
    logic [3:0] bank_c, tens_c, units_c;
    logic [6:0] innum_c;
    logic [7:0] val_c;
    logic [15:0] sum_c;
    logic in_ok_c, lvl_c, jump_c, bad_cmd_c, bad_bcd_c, range_bad_c;
    logic load_c, step_c, inval_c, bcderr_c;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Pins from outside the clock domain
    input_sync #(.W(100)) aux_sync (
        .clk(CORE_CLK),
        .rst(RST),
        .d(AUX_IN),
        .q(aux_in_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel: address and data taken in either order
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            aw_hold_ff <= 1'b0;
            awready_ff <= 1'b1;
            awaddr_ff <= 8'h00;
        end else if (S_AXI_AWVALID && awready_ff) begin
            aw_hold_ff <= 1'b1;
            awready_ff <= 1'b0;
            awaddr_ff <= S_AXI_AWADDR;
        end else if (bvalid_ff && S_AXI_BREADY) begin
            aw_hold_ff <= 1'b0;
            awready_ff <= 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            w_hold_ff <= 1'b0;
            wready_ff <= 1'b1;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
        end else if (S_AXI_WVALID && wready_ff) begin
            w_hold_ff <= 1'b1;
            wready_ff <= 1'b0;
            wdata_ff <= S_AXI_WDATA;
            wstrb_ff <= S_AXI_WSTRB;
        end else if (bvalid_ff && S_AXI_BREADY) begin
            w_hold_ff <= 1'b0;
            wready_ff <= 1'b1;
        end
    end

    assign wr_en_c = aw_hold_ff && w_hold_ff && !bvalid_ff;
    assign wr_err_c = ({awaddr_ff[7:2], 2'b00} > `OFS_ENABLE);

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `RESP_OKAY;
        end else if (wr_en_c) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_err_c ? `RESP_SLVERR : `RESP_OKAY;
        end else if (S_AXI_BREADY) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Control registers; writes to read-only words are dropped silently
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            op_ff <= `RST_OP;
            offset_ff <= `RST_OFFSET;
            jlen_ff <= `RST_JLEN;
            codes_ff <= `RST_CODES;
            exp_fitted_ff <= 1'b0;
            enable_ff <= `RST_ENABLE;
        end else if (wr_en_c) begin
            case ({awaddr_ff[7:2], 2'b00})
                `OFS_OP: op_ff <= 14'(merge(32'(op_ff), wdata_ff, wstrb_ff));
                `OFS_OFFSET: offset_ff <= 14'(merge(32'(offset_ff), wdata_ff, wstrb_ff));
                `OFS_JLEN: jlen_ff <= 7'(merge(32'(jlen_ff), wdata_ff, wstrb_ff));
                `OFS_CODES: codes_ff <= 20'(merge(32'(codes_ff), wdata_ff, wstrb_ff));
                `OFS_CONFIG: begin
                    if (wstrb_ff[0]) begin
                        exp_fitted_ff <= wdata_ff[0];
                    end
                end
                `OFS_ENABLE: enable_ff <= 4'(merge(32'(enable_ff), wdata_ff, wstrb_ff));
                default: ;
            endcase
        end
    end

    assign go_c = wr_en_c && ({awaddr_ff[7:2], 2'b00} == `OFS_GO) && wstrb_ff[0]
        && wdata_ff[0];
    assign stat_clr_c = (wr_en_c && ({awaddr_ff[7:2], 2'b00} == `OFS_CLEAR) && wstrb_ff[0])
        ? wdata_ff[3:0] : 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel, one cycle after the address is taken
    always_comb begin
        rd_data_c = 32'h00000000;
        rd_err_c = 1'b0;
        case ({S_AXI_ARADDR[7:2], 2'b00})
            `OFS_OP: rd_data_c = 32'(op_ff);
            `OFS_OFFSET: rd_data_c = 32'(offset_ff);
            `OFS_JLEN: rd_data_c = 32'(jlen_ff);
            `OFS_CODES: rd_data_c = 32'(codes_ff);
            `OFS_CONFIG: rd_data_c = 32'(exp_fitted_ff);
            `OFS_GO: rd_data_c = 32'h00000000;
            `OFS_RESULT: rd_data_c = 32'(result_ff);
            `OFS_STATUS: rd_data_c = 32'(stat_ff);
            `OFS_CLEAR: rd_data_c = 32'h00000000;
            `OFS_ENABLE: rd_data_c = 32'(enable_ff);
            default: rd_err_c = 1'b1;
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= `RESP_OKAY;
        end else if (S_AXI_ARVALID && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_data_c;
            rresp_ff <= rd_err_c ? `RESP_SLVERR : `RESP_OKAY;
        end else if (rvalid_ff && S_AXI_RREADY) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Evaluation sequence: a start while busy is ignored
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            st_ff <= branch_unit_pkg::ST_IDLE;
        end else begin
            case (st_ff)
                branch_unit_pkg::ST_IDLE: begin
                    if (go_c) begin
                        st_ff <= branch_unit_pkg::ST_EVAL;
                    end
                end
                branch_unit_pkg::ST_EVAL: st_ff <= branch_unit_pkg::ST_IDLE;
                default: st_ff <= branch_unit_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            snap_in_ff <= '0;
            snap_out_ff <= '0;
        end else if (go_c && st_ff == branch_unit_pkg::ST_IDLE) begin
            snap_in_ff <= aux_in_sync;
            snap_out_ff <= AUX_OUT_STATE;
        end
    end

    always_comb begin
        form_c = branch_unit_pkg::form_t'(op_ff[`OP_FORM_LSB +: 2]);
        bank_c = op_ff[`OP_BANK_LSB +: 4];
        innum_c = op_ff[`OP_INNUM_LSB +: 7];
        tens_c = snap_in_ff[8:5];
        units_c = snap_in_ff[4:1];
        bad_bcd_c = (tens_c > `BCD_DIGIT_MAX) || (units_c > `BCD_DIGIT_MAX);
        val_c = 8'h00;
        jump_c = 1'b1;
        bad_cmd_c = 1'b0;
        in_ok_c = 1'b0;
        lvl_c = 1'b0;
        case (form_c)
            branch_unit_pkg::FORM_BINARY: begin
                if (bank_c == `BANK_BIN_LO) begin
                    val_c = {4'h0, snap_in_ff[4:1]};
                end else if (bank_c == `BANK_BIN_HI) begin
                    val_c = {4'h0, snap_in_ff[8:5]};
                end else if (bank_c == `BANK_BIN_ALL) begin
                    val_c = snap_in_ff[8:1];
                end else begin
                    bad_cmd_c = 1'b1;
                end
            end
            branch_unit_pkg::FORM_DECIMAL: begin
                val_c = 8'({tens_c, 3'b000}) + 8'({tens_c, 1'b0}) + 8'(units_c);
            end
            branch_unit_pkg::FORM_SINGLE: begin
                // base and high ranges; expansion range
                in_ok_c = (innum_c != 7'h00 && innum_c <= `IN_BASE_LAST)
                    || (innum_c >= `IN_HIGH_FIRST && innum_c <= `IN_HIGH_LAST)
                    || (exp_fitted_ff && innum_c > `IN_BASE_LAST && innum_c <= `IN_EXP_LAST);
                bad_cmd_c = !in_ok_c;
                lvl_c = in_ok_c && snap_in_ff[innum_c];
                jump_c = (lvl_c == op_ff[`OP_COND_BIT]);
            end
            default: begin
                bad_cmd_c = (bank_c > `BANK_LAST);
                for (int i = 0; i < 10; i++) begin
                    // only code 1 positions are checked
                    if (!bad_cmd_c && codes_ff[2*i +: 2] == `CODE_ON
                        && !(snap_out_ff[7'(bank_c) * 7'd10 + 7'(i)]
                        && snap_in_ff[7'(bank_c) * 7'd10 + 7'(i)])) begin
                        jump_c = 1'b0;
                    end
                end
            end
        endcase
        if (form_c == branch_unit_pkg::FORM_BINARY || form_c == branch_unit_pkg::FORM_DECIMAL) begin
            sum_c = 16'(offset_ff) + 16'(val_c) * 16'(jlen_ff);
        end else begin
            sum_c = 16'(offset_ff);
        end
        range_bad_c = (sum_c > `MAX_BLOCK);
        bcderr_c = (form_c == branch_unit_pkg::FORM_DECIMAL) && bad_bcd_c;
        inval_c = !bad_cmd_c && !bcderr_c && jump_c && range_bad_c;
        load_c = !bad_cmd_c && !bcderr_c && jump_c && !range_bad_c;
        step_c = !bad_cmd_c && !jump_c;
    end

    // Sequencer strobes last one cycle
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            load_ff <= 1'b0;
            step_ff <= 1'b0;
            inval_ff <= 1'b0;
            bcderr_ff <= 1'b0;
            target_ff <= 12'h000;
        end else begin
            load_ff <= (st_ff == branch_unit_pkg::ST_EVAL) && load_c;
            step_ff <= (st_ff == branch_unit_pkg::ST_EVAL) && step_c;
            inval_ff <= (st_ff == branch_unit_pkg::ST_EVAL) && inval_c;
            bcderr_ff <= (st_ff == branch_unit_pkg::ST_EVAL) && bcderr_c;
            if (st_ff == branch_unit_pkg::ST_EVAL && load_c) begin
                target_ff <= sum_c[11:0];
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            result_ff <= 19'h00000;
        end else if (st_ff == branch_unit_pkg::ST_EVAL) begin
            result_ff <= {1'b0, step_c, load_c, sum_c};
        end else if (go_c) begin
            result_ff[`RES_BUSY_BIT] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky status; a new event wins over a clear in the same cycle
    always_comb begin
        stat_set_c = 4'h0;
        if (st_ff == branch_unit_pkg::ST_EVAL) begin
            stat_set_c[`ST_DONE_BIT] = 1'b1;
            stat_set_c[`ST_INVAL_BIT] = inval_c;
            stat_set_c[`ST_BCDERR_BIT] = bcderr_c;
            stat_set_c[`ST_BADCMD_BIT] = bad_cmd_c;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            stat_ff <= 4'h0;
            irq_ff <= 1'b0;
        end else begin
            stat_ff <= (stat_ff & ~stat_clr_c) | stat_set_c;
            irq_ff <= |(((stat_ff & ~stat_clr_c) | stat_set_c) & enable_ff);
        end
    end

    assign S_AXI_AWREADY = awready_ff;
    assign S_AXI_WREADY = wready_ff;
    assign S_AXI_BVALID = bvalid_ff;
    assign S_AXI_BRESP = bresp_ff;
    assign S_AXI_ARREADY = arready_ff;
    assign S_AXI_RVALID = rvalid_ff;
    assign S_AXI_RDATA = rdata_ff;
    assign S_AXI_RRESP = rresp_ff;
    assign BRANCH_LOAD = load_ff;
    assign BRANCH_TARGET = target_ff;
    assign BRANCH_STEP = step_ff;
    assign DIAG_INVALID_BLOCK = inval_ff;
    assign DIAG_DECIMAL_INPUT = bcderr_ff;
    assign IRQ = irq_ff;

    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    sequence eval_s;
        st_ff == branch_unit_pkg::ST_EVAL;
    endsequence

    sequence step_pulse_s;
        step_ff && !load_ff ##1 !step_ff;
    endsequence

    load_target_a: assert property (eval_s and load_c |=> load_ff && target_ff == $past(sum_c[11:0]))
        else $error("branch target not loaded from computed sum");
    bank_low_a: assert property (eval_s and form_c == branch_unit_pkg::FORM_BINARY && bank_c == 4'h1
        |-> val_c == 8'(snap_in_ff[4]) * 8'h08 + 8'(snap_in_ff[1])
        + 8'(snap_in_ff[3]) * 8'h04 + 8'(snap_in_ff[2]) * 8'h02)
        else $error("bank 1 value wrong");
    bank_high_a: assert property (eval_s and form_c == branch_unit_pkg::FORM_BINARY && bank_c == 4'h2
        |-> val_c[7:4] == 4'h0 && val_c[3] == snap_in_ff[8] && val_c[0] == snap_in_ff[5])
        else $error("bank 2 value wrong");
    bank_all_a: assert property (eval_s and form_c == branch_unit_pkg::FORM_BINARY && bank_c == 4'h3
        |-> val_c[7] == snap_in_ff[8] && val_c[0] == snap_in_ff[1])
        else $error("bank 3 value wrong");
    bin_range_a: assert property (eval_s and form_c == branch_unit_pkg::FORM_BINARY && !bad_cmd_c
        && sum_c > 16'h0BB7 |=> inval_ff && !load_ff ##1 !inval_ff)
        else $error("binary over-range not flagged");
    bcd_weight_a: assert property (eval_s and form_c == branch_unit_pkg::FORM_DECIMAL && !bad_bcd_c
        |-> sum_c == 16'(offset_ff) + 16'(jlen_ff) * (16'(snap_in_ff[8]) * 16'h0050
        + 16'(snap_in_ff[7]) * 16'h0028 + 16'(snap_in_ff[6]) * 16'h0014
        + 16'(snap_in_ff[5]) * 16'h000A + 16'(snap_in_ff[4:1])))
        else $error("decimal target wrong");
    bcd_error_a: assert property (eval_s and form_c == branch_unit_pkg::FORM_DECIMAL
        && (snap_in_ff[8:5] > 4'h9 || snap_in_ff[4:1] > 4'h9)
        |=> bcderr_ff && !load_ff && !step_ff)
        else $error("decimal error not raised");
    bcd_range_a: assert property (eval_s and form_c == branch_unit_pkg::FORM_DECIMAL && !bad_bcd_c
        && sum_c > 16'h0BB7 |=> inval_ff && !load_ff)
        else $error("decimal over-range not flagged");
    input_range_a: assert property (eval_s and form_c == branch_unit_pkg::FORM_SINGLE
        && innum_c > 7'h10 && innum_c < 7'h51 && !exp_fitted_ff
        |=> !load_ff && !step_ff && stat_ff[3])
        else $error("expansion input accepted without option");
    single_cond_a: assert property (eval_s and form_c == branch_unit_pkg::FORM_SINGLE && in_ok_c
        |=> step_ff == ($past(snap_in_ff[innum_c]) != $past(op_ff[13])))
        else $error("single input condition wrong");
    compare_fail_a: assert property (eval_s and form_c == branch_unit_pkg::FORM_COMPARE
        && !bad_cmd_c && !jump_c |=> step_pulse_s)
        else $error("failed compare did not step");
    target_window_a: assert property (load_ff |-> 16'(target_ff) <= 16'h0BB7)
        else $error("loaded target beyond last block");
    no_load_diag_a: assert property (inval_ff || bcderr_ff |-> !load_ff)
        else $error("pointer loaded with diagnostic");
    snapshot_hold_a: assert property (eval_s |=> $stable(snap_in_ff) && $stable(snap_out_ff))
        else $error("snapshot changed during evaluation");

endmodule

// >>> sim/aux_line_model.sv
// Far-side model: auxiliary input pins and output states seen by the unit
`timescale 1ns/1ps
module aux_line_model (
    input wire logic clk,
    input wire logic [99:0] in_set,
    input wire logic [99:0] out_set,
    output logic [99:0] aux_in,
    output logic [99:0] aux_out
);
    // All lines move together just after an edge, like a panel of switches
    always @(posedge clk) begin
        aux_in <= in_set;
        aux_out <= out_set;
    end
endmodule

// >>> sim/test_input_driven_branch_unit.sv
// Random and corner-case bench for the input-driven branch unit
`timescale 1ns/1ps
`include "branch_unit_defines.svh"
module test_input_driven_branch_unit;
    logic clk;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, load, step, dinv, ddec, irq;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    logic [11:0] tgt;
    logic [13:0] op;
    logic [99:0] ins = '0, outs = '0, aux_in, aux_out;
    int seed = 9, num_errors = 0, total_checks = 0, cycles = 0;

    input_driven_branch_unit DUT (.CORE_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .AUX_IN(aux_in), .AUX_OUT_STATE(aux_out),
        .BRANCH_LOAD(load), .BRANCH_TARGET(tgt), .BRANCH_STEP(step),
        .DIAG_INVALID_BLOCK(dinv), .DIAG_DECIMAL_INPUT(ddec), .IRQ(irq));
    aux_line_model partner (.clk(clk), .in_set(ins), .out_set(outs), .aux_in(aux_in),
        .aux_out(aux_out));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // A hung handshake would otherwise stall the run forever
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    // Returns {decimal error, invalid block, step, load, target}
    function automatic logic [15:0] predict(input logic [13:0] o, input logic [13:0] ofs,
        input logic [6:0] jl, input logic [19:0] cd, input logic cfg);
        logic [3:0] b;
        logic [6:0] n;
        logic [15:0] v;
        logic [15:0] s;
        logic ok;
        logic j;
        b = o[5:2];
        n = o[12:6];
        ok = 1'b1;
        j = 1'b1;
        v = 16'h0;
        case (o[1:0])
            2'h0: begin
                ok = b >= 4'h1 && b <= 4'h3;
                v = (b == 4'h1) ? ins[4:1] : (b == 4'h2) ? ins[8:5] : ins[8:1];
            end
            2'h1: v = 16'h000A * ins[8:5] + ins[4:1];
            2'h2: begin
                ok = (n >= 7'h01 && n <= 7'h10) || (n >= 7'h51 && n <= 7'h58)
                    || (cfg && n >= 7'h11 && n <= 7'h50);
                j = ins[n] == o[13];
            end
            default: begin
                ok = b <= 4'h9;
                for (int i = 0; i < 10 && ok; i++) begin
                    if (cd[2*i +: 2] == 2'h1 && !(ins[10*b+i] && outs[10*b+i])) j = 1'b0;
                end
            end
        endcase
        s = {2'h0, ofs} + v * {9'h0, jl};
        if (!ok) return 16'h0;
        if (o[1:0] == 2'h1 && (ins[8:5] > 4'h9 || ins[4:1] > 4'h9)) return 16'h8000;
        if (!j) return 16'h2000;
        if (s > `MAX_BLOCK) return 16'h4000;
        return {4'h1, s[11:0]};
    endfunction
    task automatic run(input logic [13:0] o, input logic [13:0] ofs, input logic [6:0] jl,
        input logic [19:0] cd, input logic cfg);
        logic [15:0] e;
        logic [3:0] got;
        axw(`OFS_OP, {18'h0, o}, r);
        axw(`OFS_OFFSET, {18'h0, ofs}, r);
        axw(`OFS_JLEN, {25'h0, jl}, r);
        axw(`OFS_CODES, {12'h0, cd}, r);
        axw(`OFS_CONFIG, {31'h0, cfg}, r);
        e = predict(o, ofs, jl, cd, cfg);
        got = 4'h0;
        axw(`OFS_GO, 32'h1, r);
        repeat (4) begin
            @(negedge clk);
            got = got | {ddec, dinv, step, load};
            if (load === 1'b1) chk("target", tgt, e[11:0]);
        end
        chk("outcome", got, e[15:12]);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        axr(`OFS_CODES, d, r);
        chk("codes reset", d, {12'h0, `RST_CODES});
        axw(8'h28, 32'h1, r);
        chk("bresp", r, `RESP_SLVERR);
        axr(8'h28, d, r);
        chk("rresp", r, `RESP_SLVERR);
        ins = 100'hA6;
        run(14'h0001, 14'h0064, 7'h0C, `RST_CODES, 1'b0);
        chk("example", tgt, 12'h2E0);
        ins = 100'h0;
        run(14'h000C, 14'h0BB7, 7'h05, `RST_CODES, 1'b0);
        run(14'h000C, 14'h0BB8, 7'h05, `RST_CODES, 1'b0);
        ins = 100'h20000;
        run(14'h2442, 14'h0010, 7'h00, `RST_CODES, 1'b0);
        run(14'h2442, 14'h0010, 7'h00, `RST_CODES, 1'b1);
        ins = 100'hC00;
        outs = 100'h1C00;
        run(14'h0007, 14'h0020, 7'h00, 20'hAAA95, 1'b0);
        axw(`OFS_CLEAR, 32'hF, r);
        axw(`OFS_ENABLE, 32'h0, r);
        run(14'h000C, 14'h0005, 7'h01, `RST_CODES, 1'b0);
        chk("irq masked", irq, 1'b0);
        axr(`OFS_STATUS, d, r);
        chk("status", d, 32'h1);
        axr(`OFS_RESULT, d, r);
        chk("result", d, 32'h00010005);
        axw(`OFS_ENABLE, 32'h1, r);
        @(negedge clk);
        chk("irq", irq, 1'b1);
        axw(`OFS_CLEAR, 32'h1, r);
        @(negedge clk);
        chk("irq cleared", irq, 1'b0);
        for (int k = 0; k < 60; k++) begin
            op = 14'($random(seed));
            if (op[1:0] == 2'h0) op[5:4] = 2'h0;
            ins = 100'({$random(seed), $random(seed), $random(seed), $random(seed)});
            outs = 100'({$random(seed), $random(seed), $random(seed), $random(seed)});
            run(op, 14'({$random(seed)} % 3300), 7'($random(seed)), 20'($random(seed)),
                1'($random(seed)));
        end
        // A second reset in mid-run must clear every strobe, the status and the interrupt
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("reset outputs", {irq, ddec, dinv, step, load, tgt}, 32'h0);
        axr(`OFS_STATUS, d, r);
        chk("status reset", d, 32'h0);
        summarize();
    end
endmodule
